// ==== test/limit_partner.sv ====
// model of the two limit switches and the stop push-button
`timescale 1ns/1ns
`default_nettype none

module limit_partner (
    input  wire logic fwd_closed_in,
    input  wire logic rev_closed_in,
    input  wire logic stop_on_in,
    output logic      fwd_pin_out,
    output logic      rev_pin_out,
    output logic      stop_pin_out
);
    // pull-up: an open contact reads high, a closed one pulls the pin low
    assign fwd_pin_out  = !fwd_closed_in;
    assign rev_pin_out  = !rev_closed_in;
    // the button pin idles low and reads high while held
    assign stop_pin_out = stop_on_in;
endmodule : limit_partner
`default_nettype wire

// ==== test/limit_switch_and_input_role_logic_tb.sv ====
// self-checking bench for the limit and input role block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end

module limit_switch_and_input_role_logic_tb;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fcl = 0, rcl = 0, son = 0, flt = 0;
    logic [11:0] paddr = 0, a = 0, b = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic prdy, perr, se, irq, fp, rp, cp, dfwd, drev, lat, est, aux;
    logic [11:0] spd, tpos;
    logic [1:0] tmo;
    logic [2:0] amo;
    int err_count = 0, num_checks = 0;
    // 125 MHz core clock
    always #4 clk = ~clk;
    limit_role_top #(.PAUSE_CYC(8), .DEB_CYC(2)) dut_u (.core_clk_in(clk), .rst_in(rst),
        .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd),
        .pstrb_in(4'hF), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .irq_out(irq),
        .fwd_limit_in(fp), .rev_limit_in(rp), .ctrl_in_a(a), .ctrl_in_b(b), .ctrl_in_c(cp),
        .pos_fwd_req_in(1'b0), .pos_rev_req_in(1'b0), .fault_in(flt), .drive_fwd_out(dfwd),
        .drive_rev_out(drev), .speed_out(spd), .target_pos_out(tpos), .latch_out(lat),
        .estop_out(est), .aux_supply_or_fault_out(aux), .trig_mode_out(tmo), .active_mode_out(amo));
    limit_partner sw_u (.fwd_closed_in(fcl), .rev_closed_in(rcl), .stop_on_in(son),
        .fwd_pin_out(fp), .rev_pin_out(rp), .stop_pin_out(cp));

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // one apb transfer; pready, prdata and pslverr are taken at the rising edge that ends it
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
        if (prdy !== 1'b1) begin err_count++; stop_test; end
        rd = prd;
        se = perr;
        psel <= 0; pen <= 0;
    endtask : apb

    // ends mid-cycle so outputs are settled when looked at
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc

    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        apb(0, 12'h080, 0); `CHK(rd, 32'h0)
        `CHK(tmo, 2'h0)
        apb(0, 12'h0FC, 0); `CHK(se, 1'b1)
        $display("test reset done");
        // low-level trip in single speed mode, pause after release
        a <= 12'h123; b <= 12'h800;
        apb(1, 12'h090, 32'h1); cyc(4);
        `CHK(dfwd, 1'b1)
        `CHK(spd, 12'h123)
        @(posedge clk) fcl <= 1; cyc(12);
        `CHK(dfwd, 1'b0)
        `CHK(irq, 1'b1)
        apb(1, 12'h08C, 32'h1); cyc(1); `CHK(irq, 1'b0)
        @(posedge clk) fcl <= 0; cyc(8);
        `CHK(dfwd, 1'b0)
        cyc(20); `CHK(dfwd, 1'b1)
        $display("test level done");
        // falling edge pulse holds forward until a reverse request
        apb(1, 12'h080, 32'h2);
        apb(0, 12'h080, 0); `CHK(rd, 32'h2)
        `CHK(tmo, 2'h2)
        @(posedge clk) fcl <= 1; cyc(12);
        `CHK(dfwd, 1'b0)
        @(posedge clk) fcl <= 0; cyc(30);
        `CHK(dfwd, 1'b0)
        @(posedge clk) begin b <= 0; son <= 1; end cyc(14);
        `CHK(drev, 1'b1)
        // falling edge pulse on reverse holds reverse
        @(posedge clk) rcl <= 1; cyc(12);
        `CHK(drev, 1'b0)
        @(posedge clk) rcl <= 0; cyc(30);
        `CHK(drev, 1'b0)
        // high level: open reverse contact blocks reverse
        apb(1, 12'h080, 32'h1); cyc(4);
        `CHK(drev, 1'b0)
        @(posedge clk) rcl <= 1; cyc(30);
        `CHK(drev, 1'b1)
        // rising edge pulse holds reverse
        apb(1, 12'h080, 32'h3);
        @(posedge clk) rcl <= 0; cyc(12);
        `CHK(drev, 1'b0)
        @(posedge clk) rcl <= 1; cyc(30);
        `CHK(drev, 1'b0)
        $display("test edge done");
        // role decode of each mode other than single speed
        apb(1, 12'h080, 32'h0);
        @(posedge clk) begin rcl <= 0; a <= 12'h005; b <= 12'h800; end
        apb(1, 12'h084, 32'h1); cyc(14);
        `CHK(tpos, 12'h005)
        `CHK(lat, 1'b1)
        `CHK(est, 1'b1)
        @(posedge clk) begin son <= 0; a <= 12'h010; end
        apb(1, 12'h084, 32'h2); cyc(14);
        `CHK(spd, 12'h010)
        `CHK(dfwd, 1'b1)
        apb(1, 12'h084, 32'h3); cyc(2);
        `CHK(spd, 12'h800)
        @(posedge clk) a <= 12'h900;
        apb(1, 12'h084, 32'h4); cyc(2);
        `CHK(spd, 12'h100)
        `CHK(dfwd, 1'b1)
        @(posedge clk) son <= 1; cyc(14);
        `CHK(est, 1'b1)
        `CHK(dfwd, 1'b0)
        @(posedge clk) son <= 0; cyc(14);
        apb(1, 12'h084, 32'h5); cyc(2);
        `CHK(aux, 1'b0)
        `CHK(drev, 1'b1)
        `CHK(amo, 3'h5)
        // stop input halts without an emergency stop, fault follows its input
        @(posedge clk) begin son <= 1; flt <= 1; end cyc(14);
        `CHK(drev, 1'b0)
        `CHK(est, 1'b0)
        `CHK(aux, 1'b1)
        $display("test roles done");
        stop_test;
    end
endmodule : limit_switch_and_input_role_logic_tb
`default_nettype wire

// ==== verilog/limit_consts.svh ====
// offsets, field positions, reset values and timing figures of the limit block
`ifndef LIMIT_CONSTS_SVH
`define LIMIT_CONSTS_SVH

`define LIM_CFG_OFS        12'h080
`define LIM_MODE_OFS       12'h084
`define LIM_STATUS_OFS     12'h088
`define LIM_IRQ_STAT_OFS   12'h08C
`define LIM_IRQ_MASK_OFS   12'h090

`define LIM_CFG_TRIG_LSB   0
`define LIM_MODE_SEL_LSB   0
`define LIM_CFG_RST        2'h0
`define LIM_MODE_RST       3'h0
`define LIM_IRQ_MASK_RST   3'h0

`define LIM_IRQ_FWD_BIT    0
`define LIM_IRQ_REV_BIT    1
`define LIM_IRQ_ESTOP_BIT  2

`define LIM_CLK_PERIOD_NS  8
`define LIM_DEBOUNCE_NS    2000
`define LIM_PAUSE_MS       50

`endif

// ==== verilog/limit_debounce.sv ====
// three-flop synchroniser and stability filter for one switch pin
`timescale 1ns/1ns
`default_nettype none
`include "limit_consts.svh"

module limit_debounce #(
    parameter int   DEB_CYC = (`LIM_DEBOUNCE_NS + `LIM_CLK_PERIOD_NS - 1) / `LIM_CLK_PERIOD_NS,
    parameter logic INIT    = 1'b1
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    localparam int DW = $clog2(DEB_CYC + 1);

    logic [2:0]    sync_ff;
    logic [DW-1:0] cnt_ff;
    logic          level_ff;
    logic          agree;

    if (DEB_CYC < 1) begin : g_bad_deb
        $error("DEB_CYC must be at least one");
    end

    // the first flop feeds only the second
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sync_ff <= {3{INIT}};
        end else begin
            sync_ff <= {sync_ff[1:0], pin_in};
        end
    end

    assign agree = (sync_ff[1] == sync_ff[2]);

    // new level must hold for the whole window, bounce restarts it
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_ff   <= '0;
            level_ff <= INIT;
        end else if (agree && (sync_ff[2] != level_ff)) begin
            if (cnt_ff == DW'(DEB_CYC - 1)) begin
                cnt_ff   <= '0;
                level_ff <= sync_ff[2];
            end else begin
                cnt_ff <= cnt_ff + DW'(1);
            end
        end else begin
            cnt_ff <= '0;
        end
    end

    assign level_out = level_ff;

    chk_deb_full_window: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $changed(level_ff) |-> ($past(cnt_ff) == DW'(DEB_CYC - 1)))
        else $error("level changed before the debounce window closed");
endmodule : limit_debounce

`default_nettype wire

// ==== verilog/limit_pkg.sv ====
// types shared by the limit switch and input role logic
package limit_pkg;
    // trigger polarity and style of both limit inputs
    typedef enum logic [1:0] {
        TRIG_LOW_LEVEL,
        TRIG_HIGH_LEVEL,
        TRIG_FALL_EDGE,
        TRIG_RISE_EDGE
    } trig_mode_e;

    // role assignment of the three general inputs
    typedef enum logic [2:0] {
        MODE_SINGLE_SPEED,
        MODE_SINGLE_POS,
        MODE_DUAL_IND_SPEED,
        MODE_DUAL_IND_POS,
        MODE_DUAL_COORD,
        MODE_ANALOG_LEVEL
    } ctrl_mode_e;
endpackage : limit_pkg

// ==== verilog/limit_role_top.sv ====
// limit switch evaluation, input role decode and apb register file
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "limit_consts.svh"

module limit_role_top #(
    parameter int W         = 12,
    parameter int PAUSE_CYC = (`LIM_PAUSE_MS * 1000000 + `LIM_CLK_PERIOD_NS - 1) / `LIM_CLK_PERIOD_NS,
    parameter int DEB_CYC   = (`LIM_DEBOUNCE_NS + `LIM_CLK_PERIOD_NS - 1) / `LIM_CLK_PERIOD_NS
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_in,
    input  wire logic [11:0]          paddr_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [31:0]          pwdata_in,
    input  wire logic [3:0]           pstrb_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output logic                      irq_out,
    input  wire logic                 fwd_limit_in,
    input  wire logic                 rev_limit_in,
    input  wire logic [W-1:0]         ctrl_in_a,
    input  wire logic [W-1:0]         ctrl_in_b,
    input  wire logic                 ctrl_in_c,
    input  wire logic                 pos_fwd_req_in,
    input  wire logic                 pos_rev_req_in,
    input  wire logic                 fault_in,
    output logic                      drive_fwd_out,
    output logic                      drive_rev_out,
    output logic [W-1:0]              speed_out,
    output logic [W-1:0]              target_pos_out,
    output logic                      latch_out,
    output logic                      estop_out,
    output logic                      aux_supply_or_fault_out,
    output limit_pkg::trig_mode_e     trig_mode_out,
    output limit_pkg::ctrl_mode_e     active_mode_out
);
    import limit_pkg::*;

    localparam int CW = $clog2(PAUSE_CYC + 1);

    if (W < 2 || W > 32) begin : g_bad_w
        $error("W must lie between 2 and 32");
    end
    if (PAUSE_CYC < 2) begin : g_bad_pause
        $error("PAUSE_CYC must be at least two");
    end

    // level styles stop while active and through the pause after release, edge styles stop while active and latch a hold, with no pause
    function automatic logic is_level(input trig_mode_e t);
        return (t == TRIG_LOW_LEVEL) || (t == TRIG_HIGH_LEVEL);
    endfunction : is_level

    // switch counts as tripped at high for the high and rising styles
    function automatic logic lim_active(input trig_mode_e t, input logic lvl);
        return ((t == TRIG_HIGH_LEVEL) || (t == TRIG_RISE_EDGE)) ? lvl : ~lvl;
    endfunction : lim_active

    trig_mode_e     cfg_ff;
    ctrl_mode_e     mode_ff;
    logic [2:0]     irq_stat_ff;
    logic [2:0]     irq_mask_ff;
    logic           ack_ff;
    logic [31:0]    prdata_ff;
    logic [2:0]     deb;
    logic [1:0]     active;
    logic [1:0]     act_prev_ff;
    logic [1:0]     enter;
    logic [1:0]     leave;
    logic [1:0]     hold_ff;
    logic [CW-1:0]  pause_cnt_ff [2];
    logic [1:0]     pausing;
    logic [1:0]     blk;
    logic           want_fwd;
    logic           want_rev;
    logic [W-1:0]   nxt_speed;
    logic [W-1:0]   nxt_pos;
    logic           nxt_latch;
    logic           nxt_estop;
    logic           nxt_aux;
    logic           b_hi;
    logic [W-1:0]   coord_mag;
    logic           drive_fwd_ff;
    logic           drive_rev_ff;
    logic [W-1:0]   speed_ff;
    logic [W-1:0]   pos_ff;
    logic           latch_ff;
    logic           estop_ff;
    logic           aux_ff;
    logic           estop_prev_ff;
    logic [2:0]     irq_ev;
    logic           acc;
    logic           wr_en;
    logic           addr_ok;
    logic [31:0]    rd_mux;

    // limits idle high through their pull-ups, the stop input idles low
    for (genvar i = 0; i < 3; i++) begin : g_deb
        limit_debounce #(
            .DEB_CYC (DEB_CYC),
            .INIT    ((i == 2) ? 1'b0 : 1'b1)
        ) u_deb (
            .core_clk_in (core_clk_in),
            .rst_in      (rst_in),
            .pin_in      ((i == 0) ? fwd_limit_in : ((i == 1) ? rev_limit_in : ctrl_in_c)),
            .level_out   (deb[i])
        );
    end

    // ------------------------------------------------------------ apb slave
    // one wait state so read data can come from a flop
    assign acc     = psel_in && penable_in;
    assign wr_en   = acc && ack_ff && pwrite_in && pstrb_in[0];
    assign addr_ok = (paddr_in == `LIM_CFG_OFS) || (paddr_in == `LIM_MODE_OFS) ||
                     (paddr_in == `LIM_STATUS_OFS) || (paddr_in == `LIM_IRQ_STAT_OFS) ||
                     (paddr_in == `LIM_IRQ_MASK_OFS);

    // read mux, unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            `LIM_CFG_OFS:      rd_mux[1:0] = cfg_ff;
            `LIM_MODE_OFS:     rd_mux[2:0] = mode_ff;
            `LIM_STATUS_OFS:   rd_mux[7:0] = {estop_ff, drive_rev_ff, drive_fwd_ff, |pausing,
                                              hold_ff, active};
            `LIM_IRQ_STAT_OFS: rd_mux[2:0] = irq_stat_ff;
            `LIM_IRQ_MASK_OFS: rd_mux[2:0] = irq_mask_ff;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // ack alternates so each access phase lasts exactly two cycles
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_ff    <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (acc && !ack_ff) begin
            ack_ff    <= 1'b1;
            prdata_ff <= rd_mux;
        end else begin
            ack_ff <= 1'b0;
        end
    end

    assign pready_out  = acc && ack_ff;
    assign pslverr_out = acc && ack_ff && !addr_ok;
    assign prdata_out  = prdata_ff;

    // configuration, defaults give normally open switches
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cfg_ff      <= trig_mode_e'(`LIM_CFG_RST);
            mode_ff     <= ctrl_mode_e'(`LIM_MODE_RST);
            irq_mask_ff <= `LIM_IRQ_MASK_RST;
        end else if (wr_en) begin
            if (paddr_in == `LIM_CFG_OFS) begin
                cfg_ff <= trig_mode_e'(pwdata_in[`LIM_CFG_TRIG_LSB +: 2]);
            end
            if (paddr_in == `LIM_MODE_OFS) begin
                mode_ff <= ctrl_mode_e'(pwdata_in[`LIM_MODE_SEL_LSB +: 3]);
            end
            if (paddr_in == `LIM_IRQ_MASK_OFS) begin
                irq_mask_ff <= pwdata_in[2:0];
            end
        end
    end

    // sticky events, a new event beats a write-one clear
    assign irq_ev[`LIM_IRQ_FWD_BIT]   = enter[0];
    assign irq_ev[`LIM_IRQ_REV_BIT]   = enter[1];
    assign irq_ev[`LIM_IRQ_ESTOP_BIT] = nxt_estop && !estop_prev_ff;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_stat_ff <= 3'h0;
        end else if (wr_en && (paddr_in == `LIM_IRQ_STAT_OFS)) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata_in[2:0]) | irq_ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_ev;
        end
    end

    assign irq_out = |(irq_stat_ff & irq_mask_ff);

    // ---------------------------------------------------- limit evaluation
    assign active = {lim_active(cfg_ff, deb[1]), lim_active(cfg_ff, deb[0])};
    assign enter  = active & ~act_prev_ff;
    assign leave  = ~active & act_prev_ff;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            act_prev_ff   <= 2'h0;
            estop_prev_ff <= 1'b0;
        end else begin
            act_prev_ff   <= active;
            estop_prev_ff <= nxt_estop;
        end
    end

    // pause timer per direction, started when a level trip releases
    for (genvar d = 0; d < 2; d++) begin : g_lim
        always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
                pause_cnt_ff[d] <= '0;
            end else if (!is_level(cfg_ff)) begin
                pause_cnt_ff[d] <= '0;
            end else if (leave[d]) begin
                pause_cnt_ff[d] <= CW'(PAUSE_CYC);
            end else if (pause_cnt_ff[d] != '0) begin
                pause_cnt_ff[d] <= pause_cnt_ff[d] - CW'(1);
            end
        end

        // edge trip latches a hold that only an opposite command or a change to a level style clears
        always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
                hold_ff[d] <= 1'b0;
            end else if (!is_level(cfg_ff) && enter[d]) begin
                hold_ff[d] <= 1'b1;
            end else if (is_level(cfg_ff) || ((d == 0) ? want_rev : want_fwd)) begin
                hold_ff[d] <= 1'b0;
            end
        end

        assign pausing[d] = (pause_cnt_ff[d] != '0);
        // release cycle blocks too, so travel never restarts before the pause
        assign blk[d] = nxt_estop || active[d] || pausing[d] || hold_ff[d] ||
                        (is_level(cfg_ff) && leave[d]);
    end

    // ------------------------------------------------------ role decode
    // digital use of b reads its top bit, a half-scale threshold
    assign b_hi      = ctrl_in_b[W-1];
    assign coord_mag = (ctrl_in_a >= ctrl_in_b) ? (ctrl_in_a - ctrl_in_b) : (ctrl_in_b - ctrl_in_a);

    always_comb begin
        want_fwd  = 1'b0;
        want_rev  = 1'b0;
        nxt_speed = '0;
        nxt_pos   = pos_ff;
        nxt_latch = 1'b0;
        nxt_estop = 1'b0;
        nxt_aux   = 1'b1;
        case (mode_ff)
            MODE_SINGLE_SPEED: begin
                nxt_speed = ctrl_in_a;
                want_fwd  = b_hi && !deb[2];
                want_rev  = deb[2] && !b_hi;
            end
            MODE_SINGLE_POS: begin
                nxt_pos   = ctrl_in_a;
                nxt_latch = b_hi;
                nxt_estop = deb[2];
                want_fwd  = pos_fwd_req_in;
                want_rev  = pos_rev_req_in;
            end
            MODE_DUAL_IND_SPEED: begin
                nxt_speed = deb[2] ? ctrl_in_b : ctrl_in_a;
                want_fwd  = !deb[2];
                want_rev  = deb[2];
            end
            MODE_DUAL_IND_POS: begin
                nxt_pos   = ctrl_in_a;
                nxt_speed = ctrl_in_b;
                nxt_estop = deb[2];
                want_fwd  = pos_fwd_req_in;
                want_rev  = pos_rev_req_in;
            end
            MODE_DUAL_COORD: begin
                nxt_speed = coord_mag;
                nxt_estop = deb[2];
                want_fwd  = (ctrl_in_a > ctrl_in_b);
                want_rev  = (ctrl_in_a < ctrl_in_b);
            end
            MODE_ANALOG_LEVEL: begin
                nxt_speed = ctrl_in_a;
                nxt_aux   = fault_in;
                want_fwd  = !b_hi && !deb[2];
                want_rev  = b_hi && !deb[2];
            end
            default: begin
                want_fwd = 1'b0;
            end
        endcase
    end

    // registered drive and role outputs
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            drive_fwd_ff <= 1'b0;
            drive_rev_ff <= 1'b0;
            speed_ff     <= '0;
            pos_ff       <= '0;
            latch_ff     <= 1'b0;
            estop_ff     <= 1'b0;
            aux_ff       <= 1'b1;
        end else begin
            drive_fwd_ff <= want_fwd && !want_rev && !blk[0];
            drive_rev_ff <= want_rev && !want_fwd && !blk[1];
            speed_ff     <= nxt_speed;
            pos_ff       <= nxt_pos;
            latch_ff     <= nxt_latch;
            estop_ff     <= nxt_estop;
            aux_ff       <= nxt_aux;
        end
    end

    assign drive_fwd_out           = drive_fwd_ff;
    assign drive_rev_out           = drive_rev_ff;
    assign speed_out               = speed_ff;
    assign target_pos_out          = pos_ff;
    assign latch_out               = latch_ff;
    assign estop_out               = estop_ff;
    assign aux_supply_or_fault_out = aux_ff;
    assign trig_mode_out           = cfg_ff;
    assign active_mode_out         = mode_ff;

    // ------------------------------------------------------- assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_fwd_release;
        is_level(cfg_ff) && leave[0];
    endsequence

    sequence s_rev_release;
        is_level(cfg_ff) && leave[1];
    endsequence

    chk_fwd_pause_load: assert property (s_fwd_release |=> (pause_cnt_ff[0] == CW'(PAUSE_CYC)) && !drive_fwd_ff)
        else $error("forward release did not start the pause");
    chk_pause_blocks: assert property ((cfg_ff == TRIG_HIGH_LEVEL) && pausing[0] |=> !drive_fwd_ff)
        else $error("forward drive ran during a pause");
    chk_rev_pause: assert property (s_rev_release |=> (pause_cnt_ff[1] == CW'(PAUSE_CYC)) && !drive_rev_ff)
        else $error("reverse release did not start the pause");
    chk_rev_lvl_stop: assert property ((cfg_ff == TRIG_HIGH_LEVEL) && deb[1] |=> !drive_rev_ff)
        else $error("reverse drive ran with its limit high");
    chk_fall_fwd_hold: assert property ((cfg_ff == TRIG_FALL_EDGE) && !deb[0] && enter[0]
        |=> hold_ff[0] && !drive_fwd_ff)
        else $error("falling forward trip did not hold");
    chk_fall_rev_hold: assert property ((cfg_ff == TRIG_FALL_EDGE) && enter[1] |=> hold_ff[1] && !drive_rev_ff)
        else $error("falling reverse trip did not hold");
    chk_rise_stop: assert property ((cfg_ff == TRIG_RISE_EDGE) && deb[0] |=> !drive_fwd_ff)
        else $error("forward drive ran with rising limit high");
    chk_hold_keeps: assert property (!is_level(cfg_ff) && hold_ff[0] && !want_rev ##1 !is_level(cfg_ff)
        |-> hold_ff[0])
        else $error("forward hold cleared without a reverse command");
    chk_single_roles: assert property ((mode_ff == MODE_SINGLE_SPEED) && !deb[2]
        |=> (speed_ff == $past(ctrl_in_a)) && (drive_rev_ff == 1'b0))
        else $error("single speed roles wrong");
    chk_pos_latch: assert property ((mode_ff == MODE_SINGLE_POS)
        |=> (latch_ff == $past(b_hi)) && (pos_ff == $past(ctrl_in_a)) && (estop_ff == $past(deb[2])))
        else $error("position roles wrong");
    chk_dual_speed: assert property ((mode_ff == MODE_DUAL_IND_SPEED) && deb[2]
        |=> (speed_ff == $past(ctrl_in_b)) && !drive_fwd_ff)
        else $error("dual speed direction select wrong");
    chk_dual_pos_stop: assert property ((mode_ff == MODE_DUAL_IND_POS) && deb[2]
        |=> estop_ff && !drive_fwd_ff && !drive_rev_ff && (speed_ff == $past(ctrl_in_b)))
        else $error("dual position stop wrong");
    chk_coord_mag: assert property ((mode_ff == MODE_DUAL_COORD) && (ctrl_in_a > ctrl_in_b) && !deb[2]
        |=> (speed_ff == $past(coord_mag)) && !drive_rev_ff)
        else $error("coordinated magnitude wrong");
    chk_aux_fault: assert property ((mode_ff == MODE_ANALOG_LEVEL) ##1 (mode_ff == MODE_ANALOG_LEVEL)
        |-> aux_ff == $past(fault_in))
        else $error("aux output not following fault");
    chk_cfg_default: assert property (@(posedge core_clk_in) disable iff (1'b0)
        $fell(rst_in) |-> (cfg_ff == TRIG_LOW_LEVEL))
        else $error("trigger default not normally open");
endmodule : limit_role_top

`default_nettype wire
